// ==== design/lsf_status_top.sv ====
// Functional notes
// - status-1 D0 set when internal temperature above its high limit
// - status-1 D1 set when internal temperature at or below low limit
// - external sensor mode: status-1 D2 set when external above high
// - analog mode: status-1 D2 flags analog input one out of window
// - status-1 D3 set when external temperature at or below low limit
// - status-1 D4 set on external sensor open or short fault
// - status-1 D5..D7 flag analog inputs two to four out of window
// - status-2 D0..D3 flag analog inputs five to eight out of window
// - status-2 D4 flags supply out of window; D5..D7 reserved
// - any set status flag drives the interrupt output active
// - status read clears only flags whose condition has gone
// - software reset clears only status flags whose condition has gone
// - temperature and supply are 10-bit; low-bits register holds two LSBs
// - low-bits D1:D0 temperature bits, D3:D2 supply bits
// - configuration bits 2:1 choose external sensor or analog input one
`timescale 1ns/100ps
`default_nettype none

module lsf_status_top (
    input  wire logic                     CLOCK_I,
    input  wire logic                     RST_N_I,
    input  wire logic [7:0]               ADDR_I,
    input  wire logic [7:0]               WDATA_I,
    input  wire logic                     WR_I,
    input  wire logic                     RD_I,
    input  wire lsf_pkg::lsf_meas_type    MEAS_I,
    input  wire lsf_pkg::lsf_limit_type   LIMIT_I,
    input  wire logic                     EXT_FAULT_I,
    output logic [7:0]                    RDATA_O,
    output logic                          INT_O
);

    ////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic addr_hit(input logic [7:0] addr,
                                      input logic [7:0] off);
        addr_hit = (addr == off);
    endfunction

    logic [7:0]                        config_r;
    logic [7:0]                        flag1_r;
    logic [7:0]                        flag2_r;
    logic [7:0]                        flag1_nxt;
    logic [7:0]                        flag2_nxt;
    logic [7:0]                        cond1;
    logic [7:0]                        cond2;
    logic [7:0]                        low_bits;
    logic [7:0]                        rdata_r;
    logic [7:0]                        rdata_nxt;
    logic                              int_r;
    logic                              fault_meta_r;
    logic                              fault_sync_r;
    logic                              ext_mode;
    logic                              rd_first;
    logic                              rd_second;
    logic                              wr_config;
    logic                              soft_reset;
    logic [lsf_pkg::LSF_NUM_CHAN-1:0]  above;
    logic [lsf_pkg::LSF_NUM_CHAN-1:0]  at_low;
    logic [lsf_pkg::LSF_NUM_CHAN-1:0]  chan_signed;

    assign rd_first   = RD_I && addr_hit(ADDR_I, lsf_pkg::LSF_OFF_STATUS_FIRST);
    assign rd_second  = RD_I && addr_hit(ADDR_I, lsf_pkg::LSF_OFF_STATUS_SECOND);
    assign wr_config  = WR_I && addr_hit(ADDR_I, lsf_pkg::LSF_OFF_CONFIG);
    assign soft_reset = wr_config && WDATA_I[lsf_pkg::LSF_SOFT_RST_BIT];
    assign ext_mode   = (config_r[lsf_pkg::LSF_MODE_LSB +: lsf_pkg::LSF_MODE_W]
                         == lsf_pkg::LSF_MODE_EXT_TEMP);

    ////////////////////////////////////////////////////////////////////////
    // configuration: mode field only; soft reset bit is a strobe

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            config_r <= lsf_pkg::LSF_CONFIG_RESET;
        end else if (wr_config) begin
            config_r <= lsf_pkg::LSF_CONFIG_RESET;
            config_r[lsf_pkg::LSF_MODE_LSB +: lsf_pkg::LSF_MODE_W] <=
                WDATA_I[lsf_pkg::LSF_MODE_LSB +: lsf_pkg::LSF_MODE_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault pin synchroniser

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            fault_meta_r <= 1'b0;
            fault_sync_r <= 1'b0;
        end else begin
            fault_meta_r <= EXT_FAULT_I;
            fault_sync_r <= fault_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // limit comparators, temperatures are twos complement

    genvar g;
    generate
        for (g = 0; g < lsf_pkg::LSF_NUM_CHAN; g++) begin : g_cmp
            assign chan_signed[g] = (g == lsf_pkg::LSF_CH_INT_TEMP) ||
                                    ((g == lsf_pkg::LSF_CH_EXT_ANALOG_INPUT_ONE) &&
                                     ext_mode);
            lsf_limit_cmp u_cmp (
                .value_i       (MEAS_I.value[g]),
                .high_i        (LIMIT_I.high[g]),
                .low_i         (LIMIT_I.low[g]),
                .signed_i      (chan_signed[g]),
                .above_o       (above[g]),
                .at_or_below_o (at_low[g])
            );
        end
    endgenerate

    always_comb begin
        cond1 = lsf_pkg::LSF_FLAGS_RESET;
        cond2 = lsf_pkg::LSF_FLAGS_RESET;
        cond1[lsf_pkg::LSF_S1_INT_HIGH] =
            above[lsf_pkg::LSF_CH_INT_TEMP];
        cond1[lsf_pkg::LSF_S1_INT_LOW] =
            at_low[lsf_pkg::LSF_CH_INT_TEMP];
        if (ext_mode) begin
            cond1[lsf_pkg::LSF_S1_EXT_HIGH] =
                above[lsf_pkg::LSF_CH_EXT_ANALOG_INPUT_ONE];
            cond1[lsf_pkg::LSF_S1_EXT_LOW] =
                at_low[lsf_pkg::LSF_CH_EXT_ANALOG_INPUT_ONE];
            cond1[lsf_pkg::LSF_S1_FAULT] = fault_sync_r;
        end else begin
            // analog pin pair: one window flag, no low or fault bit
            cond1[lsf_pkg::LSF_S1_EXT_HIGH] =
                above[lsf_pkg::LSF_CH_EXT_ANALOG_INPUT_ONE] ||
                at_low[lsf_pkg::LSF_CH_EXT_ANALOG_INPUT_ONE];
        end
        for (int k = 0; k < lsf_pkg::LSF_NUM_AIN_S1; k++) begin
            cond1[lsf_pkg::LSF_S1_ANALOG_INPUT_TWO + k] =
                above[lsf_pkg::LSF_CH_ANALOG_INPUT_TWO + k] ||
                at_low[lsf_pkg::LSF_CH_ANALOG_INPUT_TWO + k];
        end
        for (int k = 0; k < lsf_pkg::LSF_NUM_AIN_S2; k++) begin
            cond2[lsf_pkg::LSF_S2_ANALOG_INPUT_FIVE + k] =
                above[lsf_pkg::LSF_CH_ANALOG_INPUT_FIVE + k] ||
                at_low[lsf_pkg::LSF_CH_ANALOG_INPUT_FIVE + k];
        end
        cond2[lsf_pkg::LSF_S2_VDD] = above[lsf_pkg::LSF_CH_VDD] ||
                                     at_low[lsf_pkg::LSF_CH_VDD];
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky flags: a present condition always wins over a clear

    always_comb begin
        flag1_nxt = flag1_r | cond1;
        flag2_nxt = flag2_r | cond2;
        if (rd_first || soft_reset) begin
            flag1_nxt = cond1;
        end
        if (rd_second || soft_reset) begin
            flag2_nxt = cond2;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            flag1_r <= lsf_pkg::LSF_FLAGS_RESET;
            flag2_r <= lsf_pkg::LSF_FLAGS_RESET;
        end else begin
            flag1_r <= flag1_nxt;
            flag2_r <= flag2_nxt;
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            int_r <= 1'b0;
        end else begin
            int_r <= (|flag1_r) || (|flag2_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port; data stands only in the cycle after the strobe

    always_comb begin
        low_bits = lsf_pkg::LSF_FLAGS_RESET;
        low_bits[lsf_pkg::LSF_LB_TEMP_LO +: lsf_pkg::LSF_LB_PAIR_W] =
            MEAS_I.value[lsf_pkg::LSF_CH_INT_TEMP]
                        [lsf_pkg::LSF_LB_PAIR_W-1:0];
        low_bits[lsf_pkg::LSF_LB_SUPPLY_LO +: lsf_pkg::LSF_LB_PAIR_W] =
            MEAS_I.value[lsf_pkg::LSF_CH_VDD]
                        [lsf_pkg::LSF_LB_PAIR_W-1:0];
    end

    always_comb begin
        rdata_nxt = lsf_pkg::LSF_RDATA_IDLE;
        if (RD_I) begin
            if (addr_hit(ADDR_I, lsf_pkg::LSF_OFF_STATUS_FIRST)) begin
                rdata_nxt = flag1_r;
            end else if (addr_hit(ADDR_I,
                                  lsf_pkg::LSF_OFF_STATUS_SECOND)) begin
                rdata_nxt = flag2_r;
            end else if (addr_hit(ADDR_I, lsf_pkg::LSF_OFF_LOW_BITS)) begin
                rdata_nxt = low_bits;
            end else if (addr_hit(ADDR_I, lsf_pkg::LSF_OFF_CONFIG)) begin
                rdata_nxt = config_r;
            end
        end
    end

    always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rdata_r <= lsf_pkg::LSF_RDATA_IDLE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA_O = rdata_r;
    assign INT_O   = int_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);

    a_int_high_flag: assert property (
        $signed(MEAS_I.value[lsf_pkg::LSF_CH_INT_TEMP]
                 [lsf_pkg::LSF_RES_W-1:lsf_pkg::LSF_MSB_LO]) >
        $signed(LIMIT_I.high[lsf_pkg::LSF_CH_INT_TEMP])
        |=> flag1_r[lsf_pkg::LSF_S1_INT_HIGH] ##1 INT_O)
        else $error("internal high flag or interrupt missing");

    a_int_low_flag: assert property (
        $signed(MEAS_I.value[lsf_pkg::LSF_CH_INT_TEMP]
                 [lsf_pkg::LSF_RES_W-1:lsf_pkg::LSF_MSB_LO]) <=
        $signed(LIMIT_I.low[lsf_pkg::LSF_CH_INT_TEMP])
        |=> flag1_r[lsf_pkg::LSF_S1_INT_LOW])
        else $error("internal low flag missing");

    a_ext_high_flag: assert property (
        ext_mode && $signed(MEAS_I.value[lsf_pkg::LSF_CH_EXT_ANALOG_INPUT_ONE]
                 [lsf_pkg::LSF_RES_W-1:lsf_pkg::LSF_MSB_LO]) >
        $signed(LIMIT_I.high[lsf_pkg::LSF_CH_EXT_ANALOG_INPUT_ONE])
        |=> flag1_r[lsf_pkg::LSF_S1_EXT_HIGH])
        else $error("external high flag missing");

    a_ain_one_window: assert property (
        !ext_mode && (MEAS_I.value[lsf_pkg::LSF_CH_EXT_ANALOG_INPUT_ONE]
                 [lsf_pkg::LSF_RES_W-1:lsf_pkg::LSF_MSB_LO] <=
        LIMIT_I.low[lsf_pkg::LSF_CH_EXT_ANALOG_INPUT_ONE])
        |=> flag1_r[lsf_pkg::LSF_S1_EXT_HIGH])
        else $error("analog input one low flag missing");

    a_ext_low_flag: assert property (
        ext_mode && $signed(MEAS_I.value[lsf_pkg::LSF_CH_EXT_ANALOG_INPUT_ONE]
                 [lsf_pkg::LSF_RES_W-1:lsf_pkg::LSF_MSB_LO]) <=
        $signed(LIMIT_I.low[lsf_pkg::LSF_CH_EXT_ANALOG_INPUT_ONE])
        |=> flag1_r[lsf_pkg::LSF_S1_EXT_LOW])
        else $error("external low flag missing");

    a_fault_flag: assert property (
        ext_mode && fault_sync_r
        |=> flag1_r[lsf_pkg::LSF_S1_FAULT])
        else $error("sensor fault flag missing");

    a_reserved_zero: assert property (
        flag2_r[lsf_pkg::LSF_REG_W-1:lsf_pkg::LSF_S2_RSV_LO] == 3'h0)
        else $error("reserved status bits set");

    a_read_clear: assert property (
        rd_first && !soft_reset ##0 (cond1 == lsf_pkg::LSF_FLAGS_RESET)
        |=> flag1_r == lsf_pkg::LSF_FLAGS_RESET)
        else $error("status read did not clear gone flags");

    a_soft_reset: assert property (
        soft_reset |=> (flag1_r == $past(cond1)) &&
                       (flag2_r == $past(cond2)))
        else $error("software reset left stale flags");

    a_low_bits_read: assert property (
        RD_I && addr_hit(ADDR_I, lsf_pkg::LSF_OFF_LOW_BITS)
        |=> RDATA_O == $past(low_bits) ##1
            RDATA_O == lsf_pkg::LSF_RDATA_IDLE || $past(RD_I))
        else $error("low bits read data wrong");

    a_int_follows: assert property (
        (flag1_r != lsf_pkg::LSF_FLAGS_RESET) ||
        (flag2_r != lsf_pkg::LSF_FLAGS_RESET) |=> INT_O)
        else $error("interrupt not raised for a set flag");

    a_int_quiet: assert property (
        (flag1_r == lsf_pkg::LSF_FLAGS_RESET) &&
        (flag2_r == lsf_pkg::LSF_FLAGS_RESET) |=> !INT_O)
        else $error("interrupt raised with no flag set");

    a_second_clear: assert property (
        rd_second && !soft_reset ##0 (cond2 == lsf_pkg::LSF_FLAGS_RESET)
        |=> flag2_r == lsf_pkg::LSF_FLAGS_RESET)
        else $error("status two read did not clear gone flags");

    a_vdd_window: assert property (
        above[lsf_pkg::LSF_CH_VDD] || at_low[lsf_pkg::LSF_CH_VDD]
        |=> flag2_r[lsf_pkg::LSF_S2_VDD])
        else $error("supply window flag missing");

endmodule // lsf_status_top

`default_nettype wire

// ==== design/lsf_pkg.sv ====
package lsf_pkg;

    // channel layout of the measurement carrier
    localparam int LSF_NUM_CHAN    = 10;
    localparam int LSF_RES_W       = 10;
    localparam int LSF_LIM_W       = 8;
    localparam int LSF_REG_W       = 8;
    localparam int LSF_ADDR_W      = 8;
    localparam int LSF_MSB_LO      = 2;

    localparam int LSF_CH_INT_TEMP = 0;
    localparam int LSF_CH_EXT_ANALOG_INPUT_ONE = 1;
    localparam int LSF_CH_ANALOG_INPUT_TWO     = 2;
    localparam int LSF_CH_ANALOG_INPUT_FIVE     = 5;
    localparam int LSF_CH_VDD      = 9;
    localparam int LSF_NUM_AIN_S1  = 3;
    localparam int LSF_NUM_AIN_S2  = 4;

    // register offsets
    localparam logic [7:0] LSF_OFF_STATUS_FIRST  = 8'h00;
    localparam logic [7:0] LSF_OFF_STATUS_SECOND = 8'h01;
    localparam logic [7:0] LSF_OFF_LOW_BITS      = 8'h03;
    localparam logic [7:0] LSF_OFF_CONFIG        = 8'h18;

    // first status register fields
    localparam int LSF_S1_INT_HIGH = 0;
    localparam int LSF_S1_INT_LOW  = 1;
    localparam int LSF_S1_EXT_HIGH = 2;
    localparam int LSF_S1_EXT_LOW  = 3;
    localparam int LSF_S1_FAULT    = 4;
    localparam int LSF_S1_ANALOG_INPUT_TWO     = 5;

    // second status register fields
    localparam int LSF_S2_ANALOG_INPUT_FIVE     = 0;
    localparam int LSF_S2_VDD      = 4;
    localparam int LSF_S2_RSV_LO   = 5;

    // low-bits register fields
    localparam int LSF_LB_TEMP_LO  = 0;
    localparam int LSF_LB_SUPPLY_LO = 2;
    localparam int LSF_LB_PAIR_W   = 2;

    // configuration register fields
    localparam int LSF_MODE_LSB    = 1;
    localparam int LSF_MODE_W      = 2;
    localparam int LSF_SOFT_RST_BIT = 7;
    localparam logic [1:0] LSF_MODE_EXT_TEMP = 2'h0;

    localparam logic [7:0] LSF_CONFIG_RESET = 8'h00;
    localparam logic [7:0] LSF_FLAGS_RESET  = 8'h00;
    localparam logic [7:0] LSF_RDATA_IDLE   = 8'h00;

    typedef struct packed {
        logic [LSF_NUM_CHAN-1:0][LSF_RES_W-1:0] value;
    } lsf_meas_type;

    typedef struct packed {
        logic [LSF_NUM_CHAN-1:0][LSF_LIM_W-1:0] high;
        logic [LSF_NUM_CHAN-1:0][LSF_LIM_W-1:0] low;
    } lsf_limit_type;

endpackage

// ==== design/lsf_limit_cmp.sv ====
`timescale 1ns/100ps
`default_nettype none

module lsf_limit_cmp (
    input  wire logic [lsf_pkg::LSF_RES_W-1:0] value_i,
    input  wire logic [lsf_pkg::LSF_LIM_W-1:0] high_i,
    input  wire logic [lsf_pkg::LSF_LIM_W-1:0] low_i,
    input  wire logic                          signed_i,
    output logic                               above_o,
    output logic                               at_or_below_o
);

    logic [lsf_pkg::LSF_LIM_W-1:0] msb_part;

    // limits are 8 bits wide, so only the upper 8 bits of the result count
    assign msb_part = value_i[lsf_pkg::LSF_RES_W-1:lsf_pkg::LSF_MSB_LO];

    always_comb begin
        if (signed_i) begin
            above_o       = $signed(msb_part) > $signed(high_i);
            at_or_below_o = $signed(msb_part) <= $signed(low_i);
        end else begin
            above_o       = msb_part > high_i;
            at_or_below_o = msb_part <= low_i;
        end
    end

endmodule // lsf_limit_cmp

`default_nettype wire

// ==== tb/lsf_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// host side of the register port: one strobe per access, no wait states
module lsf_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic [7:0]      addr_o,
    output logic [7:0]      wdata_o,
    output logic            wr_o,
    output logic            rd_o
);
    initial begin
        addr_o  = 8'h00;
        wdata_o = 8'h00;
        wr_o    = 1'h0;
        rd_o    = 1'h0;
    end

    task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_i);
        wr_o    <= 1'h1;
        addr_o  <= a;
        wdata_o <= v;
        @(posedge clk_i);
        wr_o    <= 1'h0;
    endtask

    // data only stand in the cycle after the strobe, so sample there
    task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_i);
        rd_o   <= 1'h1;
        addr_o <= a;
        @(posedge clk_i);
        rd_o   <= 1'h0;
        #1 v = rdata_i;
    endtask
endmodule // lsf_host_model

`default_nettype wire

// ==== tb/limit_status_flags_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
    n_mismatch++; $display("BAD %0t got %h expected %h", $time, got, exp); end end

module limit_status_flags_tb;
    logic                   clock_i;
    logic                   rst_n_i;
    logic                   ext_fault_i;
    logic                   int_o;
    logic                   wr_i;
    logic                   rd_i;
    logic [7:0]             addr_i;
    logic [7:0]             wdata_i;
    logic [7:0]             rdata_o;
    logic [7:0]             d;
    lsf_pkg::lsf_meas_type  meas_i;
    lsf_pkg::lsf_limit_type limit_i;
    int                     n_mismatch = 0;
    int                     cmp_count = 0;

    lsf_status_top uut (.CLOCK_I(clock_i), .RST_N_I(rst_n_i), .ADDR_I(addr_i),
        .WDATA_I(wdata_i), .WR_I(wr_i), .RD_I(rd_i), .MEAS_I(meas_i),
        .LIMIT_I(limit_i), .EXT_FAULT_I(ext_fault_i), .RDATA_O(rdata_o),
        .INT_O(int_o));

    lsf_host_model host (.clk_i(clock_i), .rdata_i(rdata_o), .addr_o(addr_i),
        .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));

    ////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // quiet values sit inside every window in both channel-one modes
    task automatic set_quiet;
        @(posedge clock_i);
        ext_fault_i <= 1'h0;
        for (int c = 0; c < 10; c++) begin
            meas_i.value[c][9:2] <= (c == 0) ? 8'h00 : (c == 1) ? 8'h05 : 8'h80;
        end
    endtask

    // drive one channel (10 means the fault pin), then walk the clear rules
    task automatic run_case(input int ch, input logic [7:0] msb,
                            input logic [7:0] ra, input logic [7:0] mask);
        @(posedge clock_i);
        if (ch == 10) begin
            ext_fault_i <= 1'h1;
        end else begin
            meas_i.value[ch][9:2] <= msb;
        end
        repeat (5) @(posedge clock_i);
        #1 `CHK(int_o, (mask != 8'h00))
        host.read_reg(ra, d);
        `CHK(d, mask)
        host.read_reg(ra, d);
        `CHK(d, mask)
        set_quiet();
        repeat (2) @(posedge clock_i);
        host.read_reg(ra, d);
        `CHK(d, mask)
        host.read_reg(ra, d);
        `CHK(d, 8'h00)
        repeat (2) @(posedge clock_i);
        #1 `CHK(int_o, 1'h0)
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock_i = 1'h0;
        forever #4 clock_i = ~clock_i;
    end

    initial begin
        #50000;
        n_mismatch++;
        end_of_test();
    end

    initial begin
        rst_n_i     = 1'h0;
        ext_fault_i = 1'h0;
        meas_i      = '0;
        for (int c = 0; c < 10; c++) begin
            limit_i.high[c]     = 8'hC0;
            limit_i.low[c]      = 8'h40;
            meas_i.value[c][9:2] = 8'h80;
        end
        limit_i.high[0] = 8'h20;
        limit_i.low[0]  = 8'hE0;
        limit_i.high[1] = 8'h20;
        limit_i.low[1]  = 8'h00;
        meas_i.value[0] = 10'h000;
        meas_i.value[1] = 10'h014;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'h1;
        // power-up, unmapped and write-refused reads
        host.read_reg(8'h00, d);
        `CHK(d, 8'h00)
        @(posedge clock_i);
        #1 `CHK(rdata_o, 8'h00)
        host.read_reg(8'h01, d);
        `CHK(d, 8'h00)
        host.read_reg(8'h03, d);
        `CHK(d, 8'h00)
        host.read_reg(8'h02, d);
        `CHK(d, 8'h00)
        host.write_reg(8'h00, 8'hFF);
        host.read_reg(8'h00, d);
        `CHK(d, 8'h00)
        // external sensor mode after reset
        run_case(0, 8'h21, 8'h00, 8'h01);
        run_case(0, 8'h20, 8'h00, 8'h00);
        run_case(0, 8'hFF, 8'h00, 8'h00);
        run_case(0, 8'hE0, 8'h00, 8'h02);
        run_case(0, 8'hE1, 8'h00, 8'h00);
        run_case(1, 8'h21, 8'h00, 8'h04);
        run_case(1, 8'h00, 8'h00, 8'h08);
        run_case(1, 8'hFF, 8'h00, 8'h08);
        run_case(10, 8'h00, 8'h00, 8'h10);
        run_case(2, 8'hC1, 8'h00, 8'h20);
        run_case(3, 8'h40, 8'h00, 8'h40);
        run_case(4, 8'hC1, 8'h00, 8'h80);
        run_case(5, 8'hC1, 8'h01, 8'h01);
        run_case(6, 8'h40, 8'h01, 8'h02);
        run_case(7, 8'hC1, 8'h01, 8'h04);
        run_case(8, 8'h40, 8'h01, 8'h08);
        run_case(9, 8'hC1, 8'h01, 8'h10);
        run_case(9, 8'hC0, 8'h01, 8'h00);
        // low two bits of temperature and supply
        @(posedge clock_i);
        meas_i.value[0][1:0] <= 2'h1;
        meas_i.value[9][1:0] <= 2'h2;
        host.read_reg(8'h03, d);
        `CHK(d, 8'h09)
        @(posedge clock_i);
        meas_i.value[0][1:0] <= 2'h2;
        meas_i.value[9][1:0] <= 2'h1;
        host.read_reg(8'h03, d);
        `CHK(d, 8'h06)
        // analog pin mode: channel one unsigned, fault ignored
        host.write_reg(8'h18, 8'h02);
        host.read_reg(8'h18, d);
        `CHK(d, 8'h02)
        run_case(1, 8'h00, 8'h00, 8'h04);
        // any non-zero mode code selects the analog pins
        host.write_reg(8'h18, 8'h06);
        host.read_reg(8'h18, d);
        `CHK(d, 8'h06)
        run_case(1, 8'hFF, 8'h00, 8'h04);
        run_case(10, 8'h00, 8'h00, 8'h00);
        // software reset drops a flag whose cause has gone
        @(posedge clock_i);
        meas_i.value[2][9:2] <= 8'hC1;
        meas_i.value[5][9:2] <= 8'hC1;
        repeat (3) @(posedge clock_i);
        set_quiet();
        host.write_reg(8'h18, 8'h80);
        host.read_reg(8'h00, d);
        `CHK(d, 8'h00)
        host.read_reg(8'h01, d);
        `CHK(d, 8'h00)
        host.read_reg(8'h18, d);
        `CHK(d, 8'h00)
        end_of_test();
    end
endmodule // limit_status_flags_tb

`default_nettype wire
